// File: core/phase_error_meter.sv
`timescale 1ns/1ns
module phase_error_meter
	import spindle_sync_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire word16_t basic_pos, // basic spindle position feedback
	input wire word16_t follow_pos, // follower spindle position feedback
	input wire logic reverse, // follower turns opposite
	output word16_t err_r, // signed phase error
	output word16_t mag_r // absolute phase error
);
	// reverse rotation mirrors the follower position
	wire word16_t diff = reverse ? (basic_pos + follow_pos) : (basic_pos - follow_pos);
	// magnitude of the wrapped difference
	wire word16_t abs_diff = diff[15] ? (16'h0000 - diff) : diff;

	// register both so the compare downstream sees a clean value
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			err_r <= 16'h0000;
			mag_r <= 16'h0000;
		end else begin
			err_r <= diff;
			mag_r <= abs_diff;
		end
	end
endmodule // phase_error_meter

// File: core/spindle_sync_control.sv
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "spindle_sync_params.svh"
module spindle_sync_control
	import spindle_sync_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	// axi4-lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// sequence program pins
	input wire logic sync_mode_request_input,
	input wire logic phase_sync_request_input,
	input wire logic direction_select,
	input wire logic [3:0] spindle_connected,
	// position feedback of the selected spindles
	input wire word16_t basic_pos,
	input wire word16_t follow_pos,
	// status pins
	output logic in_sync_mode_output,
	output logic speed_sync_done_output,
	output logic phase_sync_done_output,
	// speed commands to the four serial spindles
	output word16_t spindle1_speed,
	output word16_t spindle2_speed,
	output word16_t spindle3_speed,
	output word16_t spindle4_speed
);
	// decode a selection value: {valid, index}
	function automatic logic [2:0] decode_select(input word16_t val, input logic [1:0] dflt);
		logic [2:0] res;
		res = 3'h0;
		if (val == 16'h0000) begin
			res = {1'b1, dflt}; // zero picks the default spindle
		end else if (val <= `SEL_MAX) begin
			res = {1'b1, 2'(val - 16'h0001)};
		end
		return res;
	endfunction

	// software registers
	word16_t basic_sel_r; // basic spindle selection
	word16_t follow_sel_r; // follower spindle selection
	word16_t speed_cmd_r; // basic spindle speed command
	word16_t phase_level_r; // phase attainment level
	// pin synchronisers
	logic [3:0] pin_meta_r; // first stage, read only by second
	logic [3:0] pin_sync_r; // second stage
	logic [3:0] conn_meta_r; // connection first stage
	logic [3:0] conn_sync_r; // connection second stage
	// control state
	logic in_sync_r; // synchronous mode active
	logic speed_done_r; // speed settled
	logic sel_fault_r; // request refused for bad selection
	logic [7:0] settle_r; // scans since mode entry, held once the settle count is reached
	logic [15:0] scan_cnt_r; // scan divider
	logic scan_tick_r; // one-cycle scan enable
	phase_state_t phase_r; // phase sequence state
	phase_state_t phase_nxt;
	logic [1:0] basic_idx_r; // latched basic index
	logic [1:0] follow_idx_r; // latched follower index
	logic reverse_r; // latched direction
	word16_t speed_out_r [4]; // speed command per spindle
	word16_t err; // signed phase error
	word16_t err_mag; // phase error magnitude
	// axi state
	logic aw_full_r; // write address held
	logic w_full_r; // write data held
	logic [11:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;

	// synchronised pin names
	wire logic mode_req = pin_sync_r[0];
	wire logic phase_req = pin_sync_r[1];
	wire logic dir_pin = pin_sync_r[2];

	// selection decode
	wire logic [2:0] basic_dec = decode_select(basic_sel_r, `SEL_DFLT_BASIC);
	wire logic [2:0] follow_dec = decode_select(follow_sel_r, `SEL_DFLT_FOLLOW);
	// selection is usable only if both connected and distinct
	wire logic sel_ok = basic_dec[2] && follow_dec[2]
		&& conn_sync_r[basic_dec[1:0]] && conn_sync_r[follow_dec[1:0]]
		&& (basic_dec[1:0] != follow_dec[1:0]);
	// mode is held while the request stands and selection is usable
	wire logic mode_nxt = mode_req && sel_ok;
	// phase within the attainment level
	wire logic phase_in_level = (err_mag <= phase_level_r);
	// follower speed, mirrored for reverse rotation
	wire word16_t follow_base = reverse_r ? (16'h0000 - speed_cmd_r) : speed_cmd_r;
	// trim towards zero phase error while aligning forward; with reverse_r set the trim drives the error away
	wire word16_t trim = (phase_r != PH_ALIGN) || phase_in_level ? 16'h0000
		: (err[15] ? (16'h0000 - `PHASE_TRIM) : `PHASE_TRIM);
	wire word16_t follow_speed = follow_base + trim;

	// axi decode
	wire logic wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
	wire logic rd_go = s_axi_arvalid && s_axi_arready;
	wire logic wr_hit = (aw_addr_r == `OFS_BASIC_SEL) || (aw_addr_r == `OFS_FOLLOW_SEL)
		|| (aw_addr_r == `OFS_SPEED_CMD) || (aw_addr_r == `OFS_PHASE_LEVEL);
	wire logic [31:0] status_word = {24'h000000, follow_idx_r, basic_idx_r, sel_fault_r,
		(phase_r == PH_DONE), speed_done_r, in_sync_r};
	logic [31:0] rd_word;
	logic rd_hit;

	// phase error measurement of the selected pair
	phase_error_meter u_meter (
		.ref_clk(ref_clk),
		.srst(srst),
		.basic_pos(basic_pos),
		.follow_pos(follow_pos),
		.reverse(reverse_r),
		.err_r(err),
		.mag_r(err_mag)
	);

	// read mux
	always_comb begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`OFS_BASIC_SEL: rd_word = {16'h0000, basic_sel_r};
			`OFS_FOLLOW_SEL: rd_word = {16'h0000, follow_sel_r};
			`OFS_SPEED_CMD: rd_word = {16'h0000, speed_cmd_r};
			`OFS_PHASE_LEVEL: rd_word = {16'h0000, phase_level_r};
			`OFS_STATUS: rd_word = status_word;
			`OFS_PHASE_ERR: rd_word = {16'h0000, err};
			default: rd_hit = 1'b0; // unmapped
		endcase
	end

	// write channel capture, address and data in either order
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= 12'h000;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_full_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_full_r <= 1'b0;
			end
		end
	end

	// ready flags and write response
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			// ready only while the holding slot is empty
			s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_full_r && !(s_axi_wvalid && s_axi_wready);
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// software registers, byte lanes honoured
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			basic_sel_r <= `RST_BASIC_SEL;
			follow_sel_r <= `RST_FOLLOW_SEL;
			speed_cmd_r <= `RST_SPEED_CMD;
			phase_level_r <= `RST_PHASE_LEVEL;
		end else if (wr_go) begin
			case (aw_addr_r)
				`OFS_BASIC_SEL: begin
					if (w_strb_r[0]) basic_sel_r[7:0] <= w_data_r[7:0];
					if (w_strb_r[1]) basic_sel_r[15:8] <= w_data_r[15:8];
				end
				`OFS_FOLLOW_SEL: begin
					if (w_strb_r[0]) follow_sel_r[7:0] <= w_data_r[7:0];
					if (w_strb_r[1]) follow_sel_r[15:8] <= w_data_r[15:8];
				end
				`OFS_SPEED_CMD: begin
					if (w_strb_r[0]) speed_cmd_r[7:0] <= w_data_r[7:0];
					if (w_strb_r[1]) speed_cmd_r[15:8] <= w_data_r[15:8];
				end
				`OFS_PHASE_LEVEL: begin
					if (w_strb_r[0]) phase_level_r[7:0] <= w_data_r[7:0];
					if (w_strb_r[1]) phase_level_r[15:8] <= w_data_r[15:8];
				end
				default: begin
					// unmapped write is answered with an error and dropped
				end
			endcase
		end
	end

	// two-stage pin synchronisers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pin_meta_r <= 4'h0;
			pin_sync_r <= 4'h0;
			conn_meta_r <= 4'h0;
			conn_sync_r <= 4'h0;
		end else begin
			pin_meta_r <= {1'b0, direction_select, phase_sync_request_input, sync_mode_request_input};
			pin_sync_r <= pin_meta_r;
			conn_meta_r <= spindle_connected;
			conn_sync_r <= conn_meta_r;
		end
	end

	// scan divider, one enable pulse per scan period
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			scan_cnt_r <= 16'h0000;
			scan_tick_r <= 1'b0;
		end else if (scan_cnt_r == 16'(`SCAN_CYCLES - 1)) begin
			scan_cnt_r <= 16'h0000;
			scan_tick_r <= 1'b1;
		end else begin
			scan_cnt_r <= scan_cnt_r + 16'h0001;
			scan_tick_r <= 1'b0;
		end
	end

	// synchronous mode entry and exit, once per scan
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			in_sync_r <= 1'b0;
			sel_fault_r <= 1'b0;
			basic_idx_r <= `SEL_DFLT_BASIC;
			follow_idx_r <= `SEL_DFLT_FOLLOW;
			reverse_r <= 1'b0;
		end else if (scan_tick_r) begin
			in_sync_r <= mode_nxt;
			sel_fault_r <= mode_req && !sel_ok;
			if (!in_sync_r) begin
				// selection and direction are taken at mode entry
				basic_idx_r <= basic_dec[1:0];
				follow_idx_r <= follow_dec[1:0];
				reverse_r <= dir_pin;
			end
		end
	end

	// speed settle timer after mode entry
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			settle_r <= 8'h00;
			speed_done_r <= 1'b0;
		end else if (!in_sync_r) begin
			settle_r <= 8'h00;
			speed_done_r <= 1'b0;
		end else if (scan_tick_r && !speed_done_r) begin
			settle_r <= settle_r + 8'h01;
			speed_done_r <= (settle_r == `SPEED_SETTLE_SCANS - 8'h01);
		end
	end

	// phase sequence next state
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			PH_IDLE: begin
				// request outside sync mode has no effect
				if (phase_req && in_sync_r) begin
					phase_nxt = PH_ALIGN;
				end
			end
			PH_ALIGN: begin
				// leave together with the mode, not one scan later
				if (!phase_req || !mode_nxt) begin
					phase_nxt = PH_IDLE;
				end else if (phase_in_level) begin
					phase_nxt = PH_DONE;
				end
			end
			PH_DONE: begin
				// speed change needs a fresh request
				if (!phase_req || !mode_nxt) begin
					phase_nxt = PH_IDLE;
				end
			end
			default: phase_nxt = PH_IDLE;
		endcase
	end

	// phase state register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			phase_r <= PH_IDLE;
		end else if (scan_tick_r) begin
			phase_r <= phase_nxt;
		end
	end

	// speed command routing to the spindles
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < 4; i++) begin
				speed_out_r[i] <= 16'h0000;
			end
		end else if (scan_tick_r) begin
			for (int i = 0; i < 4; i++) begin
				if (2'(i) == basic_idx_r) begin
					speed_out_r[i] <= speed_cmd_r; // basic spindle runs the command
				end else if (in_sync_r && 2'(i) == follow_idx_r) begin
					speed_out_r[i] <= follow_speed;
				end else begin
					speed_out_r[i] <= 16'h0000;
				end
			end
		end
	end

	// status pins, registered
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			in_sync_mode_output <= 1'b0;
			speed_sync_done_output <= 1'b0;
			phase_sync_done_output <= 1'b0;
		end else begin
			in_sync_mode_output <= in_sync_r;
			speed_sync_done_output <= speed_done_r;
			phase_sync_done_output <= (phase_r == PH_DONE);
		end
	end

	// speed ports from their flip-flops
	assign spindle1_speed = speed_out_r[0];
	assign spindle2_speed = speed_out_r[1];
	assign spindle3_speed = speed_out_r[2];
	assign spindle4_speed = speed_out_r[3];
endmodule // spindle_sync_control

// File: shared/spindle_sync_params.svh
`ifndef SPINDLE_SYNC_PARAMS_SVH
`define SPINDLE_SYNC_PARAMS_SVH

// register byte addresses
`define OFS_BASIC_SEL 12'h000
`define OFS_FOLLOW_SEL 12'h004
`define OFS_SPEED_CMD 12'h008
`define OFS_PHASE_LEVEL 12'h00C
`define OFS_STATUS 12'h010
`define OFS_PHASE_ERR 12'h014

// status field positions
`define ST_IN_SYNC 0
`define ST_SPEED_DONE 1
`define ST_PHASE_DONE 2
`define ST_SEL_FAULT 3
`define ST_BASIC_LO 4
`define ST_FOLLOW_LO 6

// reset values
`define RST_BASIC_SEL 16'h0000
`define RST_FOLLOW_SEL 16'h0000
`define RST_SPEED_CMD 16'h0000
`define RST_PHASE_LEVEL 16'h0010

// selection decode constants
`define SEL_MAX 16'h0004
`define SEL_DFLT_BASIC 2'h0
`define SEL_DFLT_FOLLOW 2'h1

// timing: scan period in ns, clock period in ns, settle time in scans
`define CLK_PERIOD_NS 40
`define SCAN_PERIOD_NS 10000
`define SCAN_CYCLES (`SCAN_PERIOD_NS / `CLK_PERIOD_NS)
`define SPEED_SETTLE_SCANS 8'h64

// speed trim applied while aligning phase
`define PHASE_TRIM 16'h0004

`endif

// File: shared/spindle_sync_pkg.sv
package spindle_sync_pkg;

	// phase synchronisation sequence
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_ALIGN,
		PH_DONE
	} phase_state_t;

	// speed and position word
	typedef logic [15:0] word16_t;

endpackage

// File: verification/spindle_drive_model.sv
`timescale 1ns/1ns
`include "spindle_sync_params.svh"
module spindle_drive_model
	import spindle_sync_pkg::*;
#(
	parameter word16_t FOLLOW_OFS = 16'h0040 // start offset of second drive
)(
	input wire logic ref_clk,
	input wire logic srst,
	input wire word16_t spd [4],
	input wire logic [1:0] basic_idx,
	input wire logic [1:0] follow_idx,
	output word16_t basic_pos,
	output word16_t follow_pos
);
	word16_t pos_r [4]; // shaft position per drive
	int tick_r; // step divider, one step per scan

	// each drive advances by its commanded speed once per step
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tick_r <= 0;
			pos_r <= '{16'h0000, FOLLOW_OFS, 16'h0000, 16'h0000};
		end else if (tick_r == `SCAN_CYCLES - 1) begin
			tick_r <= 0;
			for (int j = 0; j < 4; j++) pos_r[j] <= pos_r[j] + spd[j];
		end else begin
			tick_r <= tick_r + 1;
		end
	end

	assign basic_pos = pos_r[basic_idx];
	assign follow_pos = pos_r[follow_idx];
endmodule // spindle_drive_model

// File: verification/spindle_sync_control_bench.sv
`timescale 1ns/1ns
`include "spindle_sync_params.svh"
module spindle_sync_control_bench
	import spindle_sync_pkg::*;
;
	typedef struct {logic [33:0] v; logic [33:0] m;} note_t;
	localparam int BS [7] = '{0, 3, 2, 1, 5, 0, 4};
	localparam int FS [7] = '{0, 4, 2, 3, 1, 1, 0};
	localparam logic [3:0] CN [7] = '{4'hF, 4'hF, 4'hF, 4'hB, 4'hF, 4'hF, 4'hF};
	localparam logic OK [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic ref_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, spindle_connected;
	logic [1:0] s_axi_bresp, s_axi_rresp, b, f;
	logic sync_mode_request_input, phase_sync_request_input, direction_select;
	logic in_sync_mode_output, speed_sync_done_output, phase_sync_done_output;
	word16_t basic_pos, follow_pos, spindle1_speed, spindle2_speed, spindle3_speed, spindle4_speed, v, fv;
	word16_t spd [4];
	note_t rq [$];
	note_t n;
	logic [1:0] wq [$];
	int i, k, seed, compares, miscompares;

	assign spd = '{spindle1_speed, spindle2_speed, spindle3_speed, spindle4_speed};

	spindle_sync_control u_dut (.*);

	spindle_drive_model u_drv (.ref_clk, .srst, .spd, .basic_idx(b), .follow_idx(f), .basic_pos, .follow_pos);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic tally_and_finish();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one write, both channels offered together
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic bd;
		bd = 1'b0;
		wq.push_back(r);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!bd) begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				bd = 1'b1;
				s_axi_bready <= 1'b0;
			end
		end
	endtask

	// one read, expected answer noted with a mask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
		logic dd;
		dd = 1'b0;
		rq.push_back('{{r, e}, {2'h3, m}});
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!dd) begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				dd = 1'b1;
				s_axi_rready <= 1'b0;
			end
		end
	endtask

	// request pins, then settle
	task automatic step(input logic m, input logic p, input int c);
		@(posedge ref_clk);
		sync_mode_request_input <= m;
		phase_sync_request_input <= p;
		repeat (c) @(posedge ref_clk);
		#1;
	endtask

	// bounded wait for alignment
	task automatic wait_done();
		int c;
		c = 0;
		while (phase_sync_done_output !== 1'b1 && c < 20000) begin
			@(posedge ref_clk);
			c++;
		end
		#1;
	endtask

	// answers compared against the oldest note
	always @(posedge ref_clk) begin
		if (s_axi_bvalid && s_axi_bready) check("bresp", wq.pop_front(), s_axi_bresp);
		if (s_axi_rvalid && s_axi_rready) begin
			n = rq.pop_front();
			check("rdata", n.v & n.m, {s_axi_rresp, s_axi_rdata} & n.m);
		end
	end

	initial begin
		#(90000 * 40);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		s_axi_wstrb = 4'hF;
		{sync_mode_request_input, phase_sync_request_input, direction_select} = 3'h0;
		spindle_connected = 4'hF;
		b = 2'h0;
		f = 2'h1;
		seed = 89701;
		compares = 0;
		miscompares = 0;
		srst = 1'b1;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		rd(`OFS_BASIC_SEL, 32'(`RST_BASIC_SEL), 32'hFFFFFFFF, 2'h0);
		rd(`OFS_FOLLOW_SEL, 32'(`RST_FOLLOW_SEL), 32'hFFFFFFFF, 2'h0);
		rd(`OFS_PHASE_LEVEL, 32'(`RST_PHASE_LEVEL), 32'hFFFFFFFF, 2'h0);
		rd(12'h020, 32'h0, 32'hFFFFFFFF, 2'h2);
		wr(12'h020, 32'h1, 2'h2);
		// selection table, both directions
		for (i = 0; i < 7; i++) begin
			b = (BS[i] == 0) ? 2'h0 : 2'(BS[i] - 1);
			f = (FS[i] == 0) ? 2'h1 : 2'(FS[i] - 1);
			v = 16'($random(seed)) & 16'h0FFF | 16'h0001;
			fv = i[0] ? 16'h0000 - v : v;
			@(posedge ref_clk);
			spindle_connected <= CN[i];
			direction_select <= i[0];
			wr(`OFS_BASIC_SEL, 32'(BS[i]), 2'h0);
			wr(`OFS_FOLLOW_SEL, 32'(FS[i]), 2'h0);
			wr(`OFS_SPEED_CMD, 32'(v), 2'h0);
			step(1'b1, 1'b0, 600);
			check("mode", 34'(OK[i]), 34'(in_sync_mode_output));
			if (OK[i]) begin
				rd(`OFS_STATUS, 32'({f, b, 4'h1}), 32'hFF, 2'h0);
				for (k = 0; k < 4; k++) begin
					check("speed", 34'((k == b) ? v : (k == f) ? fv : 16'h0000), 34'(spd[k]));
				end
			end else begin
				rd(`OFS_STATUS, 32'h8, 32'h8, 2'h0);
			end
			step(1'b0, 1'b0, 600);
			check("mode", 34'h0, 34'(in_sync_mode_output));
		end
		step(1'b0, 1'b1, 600);
		check("phase", 34'h0, 34'(phase_sync_done_output));
		// second reset lines the drives up again
		@(posedge ref_clk);
		srst <= 1'b1;
		spindle_connected <= 4'hF;
		direction_select <= 1'b0;
		b <= 2'h0;
		f <= 2'h1;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		wr(`OFS_SPEED_CMD, 32'h8, 2'h0);
		step(1'b1, 1'b0, 600);
		step(1'b1, 1'b1, 0);
		wait_done();
		check("phase", 34'h1, 34'(phase_sync_done_output));
		step(1'b1, 1'b0, 600);
		check("phase", 34'h0, 34'(phase_sync_done_output));
		wr(`OFS_SPEED_CMD, 32'h10, 2'h0);
		step(1'b1, 1'b1, 0);
		wait_done();
		check("phase", 34'h1, 34'(phase_sync_done_output));
		// settle timer: still running here, done after its full count of scans
		check("speed_done", 34'h0, 34'(speed_sync_done_output));
		step(1'b1, 1'b1, 25000);
		check("speed_done", 34'h1, 34'(speed_sync_done_output));
		rd(`OFS_STATUS, 32'h7, 32'h7, 2'h0);
		rd(`OFS_SPEED_CMD, 32'h10, 32'hFFFFFFFF, 2'h0);
		step(1'b0, 1'b1, 600);
		check("phase", 34'h0, 34'(phase_sync_done_output));
		tally_and_finish();
	end
endmodule // spindle_sync_control_bench

bind spindle_sync_control sync_ctl_checker u_chk (.ref_clk, .srst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .sync_mode_request_input, .phase_sync_request_input,
	.in_sync_mode_output, .phase_sync_done_output);

// File: verification/spindle_sync_control_properties.sv
`timescale 1ns/1ns
module sync_ctl_checker
	import spindle_sync_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sync_mode_request_input,
	input wire logic phase_sync_request_input,
	input wire logic in_sync_mode_output,
	input wire logic phase_sync_done_output
);
	logic [8:0] mode_low_r; // cycles with mode request low
	logic [8:0] ph_low_r; // cycles with phase request low

	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	// saturating count of mode request low
	always_ff @(posedge ref_clk) begin
		if (srst || sync_mode_request_input) mode_low_r <= 9'h000;
		else if (mode_low_r != 9'h1FF) mode_low_r <= mode_low_r + 9'h001;
	end

	// saturating count of phase request low
	always_ff @(posedge ref_clk) begin
		if (srst || phase_sync_request_input) ph_low_r <= 9'h000;
		else if (ph_low_r != 9'h1FF) ph_low_r <= ph_low_r + 9'h001;
	end

	a_bresp_clears: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not cleared");
	a_rdata_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response not cleared");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	a_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response late");
	a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_reset_quiet: assert property ($fell(srst) |-> !in_sync_mode_output && !phase_sync_done_output
		&& !s_axi_bvalid && !s_axi_rvalid) else $error("outputs busy after reset");
	a_mode_drops: assert property (mode_low_r > 9'h104 |-> !in_sync_mode_output)
		else $error("mode kept without request");
	a_done_drops: assert property (ph_low_r > 9'h104 |-> !phase_sync_done_output)
		else $error("phase done kept without request");
	a_done_in_mode: assert property ($rose(phase_sync_done_output) |-> in_sync_mode_output)
		else $error("phase done outside mode");
	a_done_exit: assert property (!in_sync_mode_output [*2] |-> !phase_sync_done_output)
		else $error("phase done after mode exit");
endmodule // sync_ctl_checker
